// *** design/bfe_unit.sv ***
// Decided for this implementation: the Avalon-MM register port and the register addresses.
`timescale 1ns/10ps
// Overview of operation
// - clear zeroes field, other destination bits kept
// - insert low source bits at start position
// - signed extract replicates field top bit
// - unsigned extract zero fills above field
// - extends rotate source right 0/8/16/24 first
// - byte extends use low eight bits
// - halfword extends use low sixteen bits
// - no rotation given means rotate zero
// - condition flags never altered by operations
// - field operations accept optional condition code
module bfe_unit (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        nrst,
  // avalon-mm slave
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [3:0]  avs_byteenable,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest
);

  // =====================================================================
  // reset release through two flip-flops
  logic rst_meta_r;   // first stage, read only by the second
  logic rst_n_r;      // synchronised reset used everywhere else

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_r <= 1'b0;
      rst_n_r    <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r    <= rst_meta_r;
    end
  end

  // =====================================================================
  // state and registers
  bfe_pkg::bfe_state_t state_r;          // engine state
  logic [bfe_pkg::CTRL_W-1:0] ctrl_r;    // op, rotation, condition
  logic [31:0]      dst_r;               // destination register value
  logic [31:0]      src_r;               // source register value
  logic [4:0]       lsb_r;               // field start position
  logic [5:0]       width_r;             // field width
  logic [3:0]       flags_r;             // flags, written by software only
  logic [31:0]      result_r;            // value computed in calc
  logic             pass_r;              // condition held in calc
  logic             bad_r;               // op code not implemented
  logic             done_r;              // sticky, an operation finished
  logic             skip_r;              // last operation was suppressed
  logic             wait_r;              // waitrequest flop
  logic [31:0]      rdata_r;             // read data flop

  // bus decode
  logic             accept;              // request taken this edge
  logic             wr_acc;              // accepted write
  logic             start;               // go written with start bit
  logic [31:0]      rd_mux;              // read data before the flop

  // operand views
  bfe_pkg::bfe_op_t op;
  logic [1:0]       rot;
  logic [3:0]       cc;
  logic             cc_en;
  logic             cond_ok;
  logic             op_ok;
  logic [31:0]      calc_val;

  // unit results
  logic [31:0] clear_val, insert_val, sext_val, uext_val;
  logic [31:0] sbyte_val, shalf_val, ubyte_val, uhalf_val;

  // byte-lane merge of write data into a register word
  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    return (old_v & ~m) | (new_v & m);
  endfunction

  // =====================================================================
  // bus acceptance; requests wait while the engine is busy
  always_comb begin
    accept = (avs_read | avs_write) & wait_r & (state_r == bfe_pkg::ST_IDLE);
    wr_acc = accept & avs_write;
    start  = wr_acc & (avs_address == bfe_pkg::OFF_GO) & avs_byteenable[0]
             & avs_writedata[bfe_pkg::GO_START_BIT];
  end

  // waitrequest drops for exactly one cycle per taken request
  always_ff @(posedge core_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      wait_r  <= 1'b1;
      rdata_r <= bfe_pkg::RST_WORD;
    end else if (!wait_r) begin
      // answer given, raise waitrequest again on the next edge
      wait_r <= 1'b1;
    end else if (accept) begin
      wait_r <= 1'b0;
      if (avs_read) begin
        rdata_r <= rd_mux;
      end
    end
  end

  // =====================================================================
  // read mux; unmapped offsets read zero
  always_comb begin
    rd_mux = 32'h0;
    case (avs_address)
      bfe_pkg::OFF_CTRL:   rd_mux = {{(32-bfe_pkg::CTRL_W){1'b0}}, ctrl_r};
      bfe_pkg::OFF_DST:    rd_mux = dst_r;
      bfe_pkg::OFF_SRC:    rd_mux = src_r;
      bfe_pkg::OFF_FIELD: begin
        rd_mux[bfe_pkg::FLD_LSB_LSB +: 5] = lsb_r;
        rd_mux[bfe_pkg::FLD_WID_LSB +: 6] = width_r;
      end
      bfe_pkg::OFF_FLAGS:  rd_mux = {28'h0, flags_r};
      bfe_pkg::OFF_GO: begin
        rd_mux[bfe_pkg::ST_BUSY_BIT] = (state_r != bfe_pkg::ST_IDLE);
        rd_mux[bfe_pkg::ST_DONE_BIT] = done_r;
        rd_mux[bfe_pkg::ST_SKIP_BIT] = skip_r;
        rd_mux[bfe_pkg::ST_BAD_BIT]  = bad_r;
      end
      bfe_pkg::OFF_RESULT: rd_mux = result_r;
      default:             rd_mux = 32'h0;
    endcase
  end

  // =====================================================================
  // operand registers written by software
  always_ff @(posedge core_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ctrl_r  <= '0;
      src_r   <= bfe_pkg::RST_WORD;
      lsb_r   <= 5'h00;
      width_r <= 6'h00;
    end else if (wr_acc) begin
      case (avs_address)
        bfe_pkg::OFF_CTRL: begin
          ctrl_r <= bfe_pkg::CTRL_W'(be_merge({{(32-bfe_pkg::CTRL_W){1'b0}}, ctrl_r},
                                              avs_writedata, avs_byteenable));
        end
        bfe_pkg::OFF_SRC: begin
          src_r <= be_merge(src_r, avs_writedata, avs_byteenable);
        end
        bfe_pkg::OFF_FIELD: begin
          if (avs_byteenable[0]) begin
            lsb_r <= avs_writedata[bfe_pkg::FLD_LSB_LSB +: 5];
          end
          if (avs_byteenable[1]) begin
            width_r <= avs_writedata[bfe_pkg::FLD_WID_LSB +: 6];
          end
        end
        default: begin
          // other offsets handled elsewhere or ignored
        end
      endcase
    end
  end

  // flags only ever change by a software write, never by an operation
  always_ff @(posedge core_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      flags_r <= bfe_pkg::RST_FLAGS;
    end else if (wr_acc && avs_address == bfe_pkg::OFF_FLAGS && avs_byteenable[0]) begin
      flags_r <= avs_writedata[3:0];
    end
  end

  // =====================================================================
  // operand decode and condition evaluation
  always_comb begin
    op    = bfe_pkg::bfe_op_t'(ctrl_r[bfe_pkg::CTRL_OP_LSB +: 4]);
    rot   = ctrl_r[bfe_pkg::CTRL_ROT_LSB +: 2];
    cc    = ctrl_r[bfe_pkg::CTRL_CC_LSB +: 4];
    cc_en = ctrl_r[bfe_pkg::CTRL_CCEN_BIT];
    case (cc)
      4'h0:    cond_ok = flags_r[bfe_pkg::FLG_Z];
      4'h1:    cond_ok = !flags_r[bfe_pkg::FLG_Z];
      4'h2:    cond_ok = flags_r[bfe_pkg::FLG_C];
      4'h3:    cond_ok = !flags_r[bfe_pkg::FLG_C];
      4'h4:    cond_ok = flags_r[bfe_pkg::FLG_N];
      4'h5:    cond_ok = !flags_r[bfe_pkg::FLG_N];
      4'h6:    cond_ok = flags_r[bfe_pkg::FLG_V];
      4'h7:    cond_ok = !flags_r[bfe_pkg::FLG_V];
      4'h8:    cond_ok = flags_r[bfe_pkg::FLG_C] & !flags_r[bfe_pkg::FLG_Z];
      4'h9:    cond_ok = !flags_r[bfe_pkg::FLG_C] | flags_r[bfe_pkg::FLG_Z];
      4'ha:    cond_ok = flags_r[bfe_pkg::FLG_N] == flags_r[bfe_pkg::FLG_V];
      4'hb:    cond_ok = flags_r[bfe_pkg::FLG_N] != flags_r[bfe_pkg::FLG_V];
      4'hc:    cond_ok = !flags_r[bfe_pkg::FLG_Z]
                         & (flags_r[bfe_pkg::FLG_N] == flags_r[bfe_pkg::FLG_V]);
      4'hd:    cond_ok = flags_r[bfe_pkg::FLG_Z]
                         | (flags_r[bfe_pkg::FLG_N] != flags_r[bfe_pkg::FLG_V]);
      default: cond_ok = 1'b1;  // always
    endcase
    // an absent condition executes unconditionally
    if (!cc_en) begin
      cond_ok = 1'b1;
    end
  end

  // =====================================================================
  // datapath units
  bfe_field u_field (
    .dst_val     (dst_r),
    .src_val     (src_r),
    .field_lsb   (lsb_r),
    .field_width (width_r),
    .clear_val   (clear_val),
    .insert_val  (insert_val),
    .sext_val    (sext_val),
    .uext_val    (uext_val)
  );

  bfe_extend u_extend (
    .src_val             (src_r),
    .rotate_right_amount (rot),
    .sbyte_val           (sbyte_val),
    .shalf_val           (shalf_val),
    .ubyte_val           (ubyte_val),
    .uhalf_val           (uhalf_val)
  );

  // result select by op code
  always_comb begin
    op_ok = 1'b1;
    case (op)
      bfe_pkg::field_clear_op:            calc_val = clear_val;
      bfe_pkg::field_insert_op:           calc_val = insert_val;
      bfe_pkg::signed_field_extract_op:   calc_val = sext_val;
      bfe_pkg::unsigned_field_extract_op: calc_val = uext_val;
      bfe_pkg::signed_byte_extend_op:     calc_val = sbyte_val;
      bfe_pkg::signed_half_extend_op:     calc_val = shalf_val;
      bfe_pkg::unsigned_byte_extend_op:   calc_val = ubyte_val;
      bfe_pkg::unsigned_half_extend_op:   calc_val = uhalf_val;
      default: begin
        // unknown op: keep the destination, flag it
        calc_val = dst_r;
        op_ok    = 1'b0;
      end
    endcase
  end

  // =====================================================================
  // engine sequence
  always_ff @(posedge core_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      state_r <= bfe_pkg::ST_IDLE;
    end else begin
      case (state_r)
        bfe_pkg::ST_IDLE: if (start) state_r <= bfe_pkg::ST_CALC;
        bfe_pkg::ST_CALC: state_r <= bfe_pkg::ST_WRBK;
        bfe_pkg::ST_WRBK: state_r <= bfe_pkg::ST_IDLE;
        default:          state_r <= bfe_pkg::ST_IDLE;
      endcase
    end
  end

  // calc stage captures the result and its condition
  always_ff @(posedge core_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      result_r <= bfe_pkg::RST_WORD;
      pass_r   <= 1'b0;
      bad_r    <= 1'b0;
    end else if (state_r == bfe_pkg::ST_CALC) begin
      result_r <= calc_val;
      pass_r   <= cond_ok;
      bad_r    <= !op_ok;
    end
  end

  // destination: software load when idle, write back only on a pass
  always_ff @(posedge core_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      dst_r <= bfe_pkg::RST_WORD;
    end else if (state_r == bfe_pkg::ST_WRBK) begin
      if (pass_r && !bad_r) begin
        dst_r <= result_r;
      end
    end else if (wr_acc && avs_address == bfe_pkg::OFF_DST) begin
      dst_r <= be_merge(dst_r, avs_writedata, avs_byteenable);
    end
  end

  // status; a new start clears done, write back sets it
  always_ff @(posedge core_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      done_r <= 1'b0;
      skip_r <= 1'b0;
    end else if (state_r == bfe_pkg::ST_WRBK) begin
      done_r <= 1'b1;
      skip_r <= !pass_r;
    end else if (start) begin
      done_r <= 1'b0;
    end
  end

  // =====================================================================
  // outputs straight from flops
  assign avs_waitrequest = wait_r;
  assign avs_readdata    = rdata_r;

endmodule

// *** design/bfe_pkg.sv ***
// =====================================================================
// bitfield / extend unit shared constants
package bfe_pkg;

  // =====================================================================
  // register byte offsets on the avalon slave
  localparam logic [4:0] OFF_CTRL   = 5'h00;  // operation, rotation, condition
  localparam logic [4:0] OFF_DST    = 5'h04;  // destination register value
  localparam logic [4:0] OFF_SRC    = 5'h08;  // source register value
  localparam logic [4:0] OFF_FIELD  = 5'h0c;  // field start and width
  localparam logic [4:0] OFF_FLAGS  = 5'h10;  // current condition flags
  localparam logic [4:0] OFF_GO     = 5'h14;  // write: start, read: status
  localparam logic [4:0] OFF_RESULT = 5'h18;  // last computed value

  // =====================================================================
  // control register fields
  localparam int CTRL_OP_LSB   = 0;   // op code, 4 bits
  localparam int CTRL_ROT_LSB  = 4;   // rotation select, 2 bits
  localparam int CTRL_CC_LSB   = 8;   // condition code, 4 bits
  localparam int CTRL_CCEN_BIT = 12;  // condition present
  localparam int CTRL_W        = 13;  // implemented control bits

  // field register layout
  localparam int FLD_LSB_LSB = 0;     // start position, 5 bits
  localparam int FLD_WID_LSB = 8;     // width, 6 bits

  // flag register bits
  localparam int FLG_N = 3;
  localparam int FLG_Z = 2;
  localparam int FLG_C = 1;
  localparam int FLG_V = 0;

  // go / status bits
  localparam int GO_START_BIT = 0;
  localparam int ST_BUSY_BIT  = 0;
  localparam int ST_DONE_BIT  = 1;
  localparam int ST_SKIP_BIT  = 2;
  localparam int ST_BAD_BIT   = 3;

  // =====================================================================
  // reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [3:0]  RST_FLAGS = 4'h0;

  // =====================================================================
  // operation codes
  typedef enum logic [3:0] {
    field_clear_op            = 4'h0,
    field_insert_op           = 4'h1,
    signed_field_extract_op   = 4'h2,
    unsigned_field_extract_op = 4'h3,
    signed_byte_extend_op     = 4'h4,
    signed_half_extend_op     = 4'h5,
    unsigned_byte_extend_op   = 4'h6,
    unsigned_half_extend_op   = 4'h7
  } bfe_op_t;

  // engine states, gray along idle -> calc -> write back
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CALC = 2'b01,
    ST_WRBK = 2'b11
  } bfe_state_t;

endpackage

// *** design/bfe_field.sv ***
`timescale 1ns/10ps
// =====================================================================
// field clear / insert / extract, purely combinational
module bfe_field (
  // operands
  input  wire logic [31:0] dst_val,
  input  wire logic [31:0] src_val,
  input  wire logic [4:0]  field_lsb,
  input  wire logic [5:0]  field_width,
  // results
  output logic [31:0]      clear_val,
  output logic [31:0]      insert_val,
  output logic [31:0]      sext_val,
  output logic [31:0]      uext_val
);

  logic [31:0] low_mask;     // width ones at bit 0
  logic [31:0] field_mask;   // width ones at the start position
  logic [31:0] shifted;      // source moved down to bit 0
  logic [4:0]  top_idx;      // index of the field's top bit
  logic        top_bit;

  // =====================================================================
  // masks; a shift by 32 yields zero so width 32 gives all ones
  always_comb begin
    low_mask   = ~(32'hffff_ffff << field_width);
    field_mask = low_mask << field_lsb;
    shifted    = src_val >> field_lsb;
    // width 0 is illegal from the issuer, guard the index anyway
    top_idx    = (field_width == 6'h00) ? 5'h00 : 5'(field_width - 6'h01);
    top_bit    = shifted[top_idx];
  end

  // =====================================================================
  // the four field results
  always_comb begin
    clear_val  = dst_val & ~field_mask;
    insert_val = (dst_val & ~field_mask) | ((src_val & low_mask) << field_lsb);
    uext_val   = shifted & low_mask;
    sext_val   = (shifted & low_mask) | (top_bit ? ~low_mask : 32'h0);
  end

endmodule

// *** design/bfe_extend.sv ***
`timescale 1ns/10ps
// =====================================================================
// rotate then byte / halfword extend, purely combinational
module bfe_extend (
  // operands
  input  wire logic [31:0] src_val,
  input  wire logic [1:0]  rotate_right_amount,
  // results
  output logic [31:0]      sbyte_val,
  output logic [31:0]      shalf_val,
  output logic [31:0]      ubyte_val,
  output logic [31:0]      uhalf_val
);

  logic [63:0] doubled;   // two copies make the rotate a plain shift
  logic [31:0] rotated;
  logic [5:0]  amount;    // 0, 8, 16 or 24 bits

  // =====================================================================
  // rotation; select 0 leaves the value exactly as read
  always_comb begin
    amount  = {1'b0, rotate_right_amount, 3'b000};
    doubled = {src_val, src_val} >> amount;
    rotated = doubled[31:0];
  end

  // =====================================================================
  // extension of the low byte or halfword
  always_comb begin
    sbyte_val = {{24{rotated[7]}}, rotated[7:0]};
    ubyte_val = {24'h0, rotated[7:0]};
    shalf_val = {{16{rotated[15]}}, rotated[15:0]};
    uhalf_val = {16'h0, rotated[15:0]};
  end

endmodule

// *** test/bfe_tb_pkg.sv ***
// ==========================
// reference model shared by the checker and the bench
package bfe_tb_pkg;

  // condition test on flags n z c v, codes 14 and 15 always pass
  function automatic logic cond_pass(input logic [3:0] cc, input logic [3:0] f);
    case (cc)
      4'h0: return f[2];
      4'h1: return !f[2];
      4'h2: return f[1];
      4'h3: return !f[1];
      4'h4: return f[3];
      4'h5: return !f[3];
      4'h6: return f[0];
      4'h7: return !f[0];
      4'h8: return f[1] && !f[2];
      4'h9: return !f[1] || f[2];
      4'ha: return f[3] == f[0];
      4'hb: return f[3] != f[0];
      4'hc: return !f[2] && (f[3] == f[0]);
      4'hd: return f[2] || (f[3] != f[0]);
      default: return 1'h1;
    endcase
  endfunction

  // expected result of one operation; width must be 1..32-lsb
  function automatic logic [31:0] model(input logic [3:0] op, input logic [1:0] rot,
      input logic [31:0] d, input logic [31:0] s, input logic [4:0] lsb, input logic [5:0] w);
    logic [63:0] m;
    logic [63:0] t;
    logic [31:0] fm;
    logic [31:0] u;
    logic [31:0] r;
    m = (64'h1 << w) - 64'h1;
    fm = m[31:0] << lsb;
    u = (s >> lsb) & m[31:0];
    t = {s, s} >> (rot * 8);
    r = t[31:0];
    case (op)
      4'h0: return d & ~fm;
      4'h1: return (d & ~fm) | ((s << lsb) & fm);
      4'h2: return u[w - 6'h01] ? (u | ~m[31:0]) : u;
      4'h3: return u;
      4'h4: return {{24{r[7]}}, r[7:0]};
      4'h5: return {{16{r[15]}}, r[15:0]};
      4'h6: return {24'h0, r[7:0]};
      4'h7: return {16'h0, r[15:0]};
      default: return d;
    endcase
  endfunction

endpackage

// *** test/bfe_issuer.sv ***
`timescale 1ns/10ps
// ==========================
// issuing side: decoder and register file as an avalon master
module bfe_issuer (
  // clock
  input  wire logic        core_clk,
  // avalon-mm master
  output logic [4:0]       avs_address,
  output logic             avs_read,
  output logic             avs_write,
  output logic [3:0]       avs_byteenable,
  output logic [31:0]      avs_writedata,
  input  wire logic [31:0] avs_readdata,
  input  wire logic        avs_waitrequest
);
  initial begin
    avs_address = 5'h1f;
    avs_read = 1'h0;
    avs_write = 1'h0;
    avs_byteenable = 4'hf;
    avs_writedata = 32'h0;
  end

  // one transfer, held until waitrequest is sampled low
  task automatic xfer(input logic wr, input logic [4:0] a, input logic [31:0] d,
      input int gap, output logic [31:0] q);
    repeat (gap + 1) @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= ~wr;
    avs_write <= wr;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'h0) @(posedge core_clk);
    q = avs_readdata;
    avs_read <= 1'h0;
    avs_write <= 1'h0;
    // released lines show junk so a stale value never passes
    avs_address <= ~a;
    avs_writedata <= ~d;
  endtask

  // loads the operands of one operation and starts it
  task automatic issue(input logic [3:0] op, input logic [1:0] rot, input logic [3:0] cc,
      input logic cen, input logic [3:0] f, input logic [31:0] dv, input logic [31:0] sv,
      input logic [4:0] lsb, inout logic [5:0] w, input int gap);
    logic [31:0] q;
    // start fits 5 bits; width folded into 1..32-lsb
    if (w == 6'h00 || w > 6'h20 - {1'h0, lsb}) w = 6'h20 - {1'h0, lsb};
    // only this unit's words, no stack or program counter
    xfer(1'h1, bfe_pkg::OFF_FLAGS, {28'h0, f}, gap, q);
    xfer(1'h1, bfe_pkg::OFF_CTRL, {19'h0, cen, cc, 2'h0, rot, op}, gap, q);
    xfer(1'h1, bfe_pkg::OFF_DST, dv, gap, q);
    xfer(1'h1, bfe_pkg::OFF_SRC, sv, gap, q);
    xfer(1'h1, bfe_pkg::OFF_FIELD, {18'h0, w, 3'h0, lsb}, gap, q);
    xfer(1'h1, bfe_pkg::OFF_GO, 32'h1, gap, q);
  endtask
endmodule

// *** test/bfe_unit_sva.sv ***
`timescale 1ns/10ps
// ==========================
// port level checker; shadows the registers from completed transfers
module bfe_unit_sva (
  // clock and reset
  input wire logic        core_clk,
  input wire logic        nrst,
  // avalon-mm slave
  input wire logic [4:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  logic [31:0] ctl_r, dst_r, src_r, fld_r, res_r;  // shadows, full words only
  logic [3:0]  flg_r, op_r;                        // flags as last written, op of last start
  logic        go_r;                               // a start has been seen
  logic        wr_ok, rd_ok, res_rd, pass_w;
  logic [31:0] exp_w;

  // a transfer completes at the edge where waitrequest is low
  assign wr_ok = avs_write && !avs_waitrequest;
  assign rd_ok = avs_read && !avs_waitrequest;
  assign res_rd = rd_ok && avs_address == bfe_pkg::OFF_RESULT && go_r;
  assign exp_w = bfe_tb_pkg::model(ctl_r[3:0], ctl_r[5:4], dst_r, src_r, fld_r[4:0],
                                   fld_r[13:8]);
  assign pass_w = !ctl_r[12] || bfe_tb_pkg::cond_pass(ctl_r[11:8], flg_r);

  // start applies the expected write back at once; reads wait for idle
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      {ctl_r, dst_r, src_r, fld_r, res_r} <= '0;
      {flg_r, op_r, go_r} <= '0;
    end else if (wr_ok) begin
      case (avs_address)
        bfe_pkg::OFF_CTRL: ctl_r <= avs_writedata;
        bfe_pkg::OFF_DST: dst_r <= avs_writedata;
        bfe_pkg::OFF_SRC: src_r <= avs_writedata;
        bfe_pkg::OFF_FIELD: fld_r <= avs_writedata;
        bfe_pkg::OFF_FLAGS: flg_r <= avs_writedata[3:0];
        bfe_pkg::OFF_GO: if (avs_writedata[0]) begin
          {go_r, op_r, res_r} <= {1'h1, ctl_r[3:0], exp_w};
          if (pass_w && !ctl_r[3]) dst_r <= exp_w;
        end
        default: ;
      endcase
    end
  end

  clr_result_a : assert property (res_rd && op_r == 4'h0 |-> avs_readdata == res_r)
    else $error("clear result wrong");
  ins_result_a : assert property (res_rd && op_r == 4'h1 |-> avs_readdata == res_r)
    else $error("insert result wrong");
  sext_result_a : assert property (res_rd && op_r == 4'h2 |-> avs_readdata == res_r)
    else $error("signed extract wrong");
  uext_result_a : assert property (res_rd && op_r == 4'h3 |-> avs_readdata == res_r)
    else $error("unsigned extract wrong");
  byte_ext_a : assert property (
    res_rd && op_r inside {4'h4, 4'h6} |-> avs_readdata == res_r) else $error("byte extend wrong");
  half_ext_a : assert property (
    res_rd && op_r inside {4'h5, 4'h7} |-> avs_readdata == res_r) else $error("half extend wrong");
  flags_kept_a : assert property (
    rd_ok && avs_address == bfe_pkg::OFF_FLAGS |-> avs_readdata[3:0] == flg_r)
    else $error("flags changed");
  dst_wrback_a : assert property (
    rd_ok && avs_address == bfe_pkg::OFF_DST |-> avs_readdata == dst_r)
    else $error("destination wrong");
  wait_pulse_a : assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  req_answer_a : assert property (
    (avs_read || avs_write) && avs_waitrequest |-> ##[0:8] !avs_waitrequest)
    else $error("request not answered");

  cover property (res_rd);
  cover property (wr_ok && avs_address == bfe_pkg::OFF_GO && !pass_w);
  cover property (rd_ok && avs_address == bfe_pkg::OFF_DST);
endmodule

// *** test/bfe_unit_tb.sv ***
`timescale 1ns/10ps
// ==========================
// self-checking bench for the bitfield unit
module bfe_unit_tb;
  logic        core_clk = 1'h0;
  logic        nrst = 1'h0;
  logic [4:0]  avs_address;
  logic        avs_read, avs_write, avs_waitrequest;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata;
  int          miscompares = 0;
  int          check_count = 0;
  int          cyc = 0;
  int          seed = 33653;

  always #50 core_clk = ~core_clk;

  bfe_unit u_bfe_unit (.*);
  bfe_issuer u_issuer (.*);

  task check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task summarize;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // hang limit, well above the run length
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      summarize();
    end
  end

  // one operation, then status, result, destination and flags compared
  task automatic run(input logic [3:0] op, input logic [1:0] rot, input logic [3:0] cc,
      input logic cen, input logic [3:0] f, input logic [31:0] dv, input logic [31:0] sv,
      input logic [4:0] lsb, input logic [5:0] w);
    logic [31:0] q, e;
    logic        ok;
    u_issuer.issue(op, rot, cc, cen, f, dv, sv, lsb, w, $unsigned($random(seed)) % 3);
    e = bfe_tb_pkg::model(op, rot, dv, sv, lsb, w);
    ok = !cen || bfe_tb_pkg::cond_pass(cc, f);
    // status read waits out the busy engine
    u_issuer.xfer(1'h0, bfe_pkg::OFF_GO, 32'h0, 0, q);
    check({28'h0, q[3], 1'h0, q[1:0]}, {28'h0, op[3], 3'h2});
    if (!op[3]) check({31'h0, q[2]}, {31'h0, ~ok});
    u_issuer.xfer(1'h0, bfe_pkg::OFF_RESULT, 32'h0, 0, q);
    if (!op[3]) check(q, e);
    u_issuer.xfer(1'h0, bfe_pkg::OFF_DST, 32'h0, 0, q);
    check(q, (ok && !op[3]) ? e : dv);
    u_issuer.xfer(1'h0, bfe_pkg::OFF_FLAGS, 32'h0, 0, q);
    check(q, {28'h0, f});
  endtask

  initial begin
    logic [31:0] q;
    repeat (3) @(posedge core_clk);
    nrst <= 1'h1;
    repeat (3) @(posedge core_clk);
    // reset values of every word, the last one unmapped
    for (int a = 0; a < 32; a += 4) begin
      u_issuer.xfer(1'h0, 5'(a), 32'h0, 0, q);
      check(q, bfe_pkg::RST_WORD);
    end
    $display("reset values done");
    // worked cases, then full width and top bit fields
    run(4'h0, 2'h0, 4'h0, 1'h0, 4'h0, 32'hffff_ffff, 32'h0, 5'h08, 6'h0c);
    run(4'h1, 2'h0, 4'h0, 1'h0, 4'h0, 32'h1234_5678, 32'habcd_e9f1, 5'h08, 6'h0c);
    run(4'h2, 2'h0, 4'h0, 1'h0, 4'h0, 32'h0, 32'h0080_0000, 5'h14, 6'h04);
    run(4'h3, 2'h0, 4'h0, 1'h0, 4'h0, 32'h0, 32'hfff7_fe00, 5'h09, 6'h0a);
    for (int o = 0; o < 4; o++) begin
      run(4'(o), 2'h0, 4'h0, 1'h0, 4'h0, 32'($random(seed)), 32'($random(seed)), 5'h00, 6'h20);
      run(4'(o), 2'h0, 4'h0, 1'h0, 4'h0, 32'h5a5a_a5a5, 32'hffff_ffff, 5'h1f, 6'h01);
    end
    $display("field ops done");
    // every extend op at every rotation
    for (int o = 4; o < 8; o++)
      for (int r = 0; r < 4; r++)
        run(4'(o), 2'(r), 4'h0, 1'h0, 4'h0, 32'h0, 32'h8f7f_f080, 5'h00, 6'h01);
    $display("extend ops done");
    // all condition codes, plus undefined op codes
    for (int c = 0; c < 16; c++)
      repeat (2) run(4'($unsigned($random(seed)) % 8), 2'($random(seed)), 4'(c), 1'h1,
        4'($random(seed)), 32'($random(seed)), 32'($random(seed)), 5'($random(seed)),
        6'($random(seed)));
    run(4'h8, 2'h0, 4'h0, 1'h0, 4'h0, 32'hc3c3_3c3c, 32'h1, 5'h00, 6'h04);
    run(4'hf, 2'h0, 4'h0, 1'h0, 4'h0, 32'h0f0f_f0f0, 32'h1, 5'h00, 6'h04);
    $display("conditions done");
    repeat (50) run(4'($unsigned($random(seed)) % 8), 2'($random(seed)), 4'($random(seed)),
      1'($random(seed)), 4'($random(seed)), 32'($random(seed)), 32'($random(seed)),
      5'($random(seed)), 6'($random(seed)));
    $display("random mix done");
    summarize();
  end
endmodule

bind bfe_unit bfe_unit_sva u_bfe_unit_sva (.*);
